// File: rtl/uart_baud_rate_generator.sv
// Baud rate generator for the asynchronous serial channel, APB slave
//
// Operation
// - An 8-bit read/write divider control register at index FF73H resets to 00H, prescaler in bits 7..4 and modulus in bits 3..0.
// - A modulus value k of 0 to 14 divides the source clock by k plus 16.
// - Modulus 1111 passes the source clock undivided and is for the clocked three-wire mode only.
// - The prescaler selects system clock over 2 to the (n-1), codes 0101..1110 giving n 1..10 and 0000 giving n 11.
// - A 5-bit counter on the selected source clock, prescaled internal or external pin, does the modulus division.
// - The system clock equals the oscillator when the oscillation mode bit is one and half of it when zero.
// - From the internal clock the bit rate is system clock over 2 to the n times (k plus 16).
// - From the external pin the bit rate is pin frequency over 2 times (k plus 16), prescaler unused.
// - The bit clock comes from either the internal or the external source, one at a time.
module uart_baud_rate_generator
(
  input  wire logic                           clock_i,
  input  wire logic                           rst_i,
  input  wire logic                           psel_i,
  input  wire logic                           penable_i,
  input  wire logic                           pwrite_i,
  input  wire logic [baud_gen_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [baud_gen_pkg::DATA_W-1:0] pwdata_i,
  input  wire logic [3:0]                     pstrb_i,
  input  wire logic                           external_baud_clock_pin_i,
  output logic                                pready_o,
  output logic                                pslverr_o,
  output logic [baud_gen_pkg::DATA_W-1:0]      prdata_o,
  output logic                                baud_clk_o,
  output logic                                baud_tick_o
);
  import baud_gen_pkg::*;

  state_type         s_q;
  state_type         s_d;

  logic              access;
  logic              commit;
  logic              hit_ctrl;
  logic              hit_cfg;
  logic              hit_stat;
  logic              mapped;
  logic              bad_write;
  logic [3:0]        pre_code;
  logic [3:0]        mod_code;
  logic [3:0]        n_val;
  logic              pre_ok;
  logic [PRE_W-1:0]  pre_mask;
  logic              sys_tick;
  logic              int_tick;
  logic              ext_tick;
  logic              src_tick;
  logic [4:0]        last_cnt;
  logic              wrap;

  // Prescaler exponent n from the prescaler code
  function automatic logic [3:0] pre_n(input logic [3:0] code);
    logic [3:0] n;
    n = '0;
    if (code == PRE_CODE_SLOW)
    begin
      n = PRE_N_SLOW;
    end
    else if (code >= PRE_CODE_MIN && code <= PRE_CODE_MAX)
    begin
      n = code - PRE_CODE_OFS;
    end
    return n;
  endfunction

  // Low (n-1) bits set: the source ticks once per 2^(n-1) system ticks
  function automatic logic [PRE_W-1:0] pre_mask_of(input logic [3:0] n);
    logic [PRE_W-1:0] m;
    m = '0;
    for (int i = 0; i < PRE_W; i++)
    begin
      if (4'(i + 1) < n)
      begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  assign pre_code  = s_q.ctrl[PRE_MSB:PRE_LSB];
  assign mod_code  = s_q.ctrl[MOD_MSB:MOD_LSB];
  assign n_val     = pre_n(pre_code);
  // Prohibited codes stall the internal source rather than guess a rate
  assign pre_ok    = (n_val != 4'h0);
  assign pre_mask  = pre_mask_of(n_val);

  // System clock tick: every edge, or every second edge when halved
  assign sys_tick  = s_q.osc_full | s_q.half_ph;
  assign int_tick  = sys_tick & pre_ok
                     & ((s_q.pre_cnt & pre_mask) == pre_mask);
  // Rising edge of the synchronised pin; second stage onward only
  assign ext_tick  = s_q.ext_sync[1] & ~s_q.ext_prev;
  assign src_tick  = s_q.int_src ? int_tick : ext_tick;

  assign last_cnt  = {1'b0, mod_code} + MOD_LAST_OFS;
  assign wrap      = src_tick
                     & ((mod_code == MOD_PASS)
                        | (s_q.div_cnt == last_cnt));

  assign access    = psel_i & penable_i;
  assign commit    = access & s_q.pready;
  assign hit_ctrl  = (paddr_i == CTRL_ADDR);
  assign hit_cfg   = (paddr_i == CFG_ADDR);
  assign hit_stat  = (paddr_i == STAT_ADDR);
  assign mapped    = hit_ctrl | hit_cfg | hit_stat;
  assign bad_write = pwrite_i & hit_stat;

  always_comb
  begin
    s_d = s_q;

    s_d.ext_sync  = {s_q.ext_sync[0], external_baud_clock_pin_i};
    s_d.ext_prev  = s_q.ext_sync[1];
    s_d.half_ph   = ~s_q.half_ph;
    s_d.baud_tick = wrap;

    if (sys_tick)
    begin
      s_d.pre_cnt = s_q.pre_cnt + 1'b1;
    end

    // 5-bit modulus counter on the selected source
    if (src_tick)
    begin
      if (wrap)
      begin
        s_d.div_cnt = '0;
      end
      else
      begin
        s_d.div_cnt = s_q.div_cnt + 1'b1;
      end
    end

    // Toggling on each wrap supplies the final divide by two
    if (wrap)
    begin
      s_d.baud_clk = ~s_q.baud_clk;
    end

    // One wait state: ready rises in the second access cycle
    s_d.pready  = access & ~s_q.pready;
    s_d.pslverr = access & ~s_q.pready & (~mapped | bad_write);
    if (access & ~s_q.pready)
    begin
      s_d.prdata = '0;
      if (!pwrite_i)
      begin
        if (hit_ctrl)
        begin
          s_d.prdata[7:0] = s_q.ctrl;
        end
        else if (hit_cfg)
        begin
          s_d.prdata[CFG_FULL_BIT] = s_q.osc_full;
          s_d.prdata[CFG_INT_BIT]  = s_q.int_src;
        end
        else if (hit_stat)
        begin
          s_d.prdata[4:0] = s_q.div_cnt;
          s_d.prdata[5]   = s_q.baud_clk;
          s_d.prdata[6]   = pre_ok;
        end
      end
    end

    if (commit & pwrite_i)
    begin
      // A write without strobe bit 0 is dropped, never merged into the byte
      if (hit_ctrl & pstrb_i[0])
      begin
        s_d.ctrl = pwdata_i[7:0];
        // Restart the divide so a new setting starts from a clean phase
        s_d.div_cnt = '0;
        s_d.pre_cnt = '0;
      end
      if (hit_cfg & pstrb_i[0])
      begin
        s_d.osc_full = pwdata_i[CFG_FULL_BIT];
        s_d.int_src  = pwdata_i[CFG_INT_BIT];
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q           <= '0;
      s_q.ctrl      <= CTRL_RESET;
      s_q.osc_full  <= CFG_RESET[CFG_FULL_BIT];
      s_q.int_src   <= CFG_RESET[CFG_INT_BIT];
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pready_o    = s_q.pready;
  assign pslverr_o   = s_q.pslverr;
  assign prdata_o    = s_q.prdata;
  assign baud_clk_o  = s_q.baud_clk;
  assign baud_tick_o = s_q.baud_tick;

endmodule // uart_baud_rate_generator

// File: inc/baud_gen_pkg.sv
// Constants and types for the serial baud rate generator
package baud_gen_pkg;

  localparam int          ADDR_W        = 20;
  localparam int          DATA_W        = 32;

  // Register indexes; byte address is four times the index
  localparam logic [17:0] CTRL_IDX      = 18'h0_ff73;
  localparam logic [17:0] CFG_IDX       = 18'h0_ff7e;
  localparam logic [17:0] STAT_IDX      = 18'h0_ff7f;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] CFG_ADDR  = {CFG_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] STAT_ADDR = {STAT_IDX, 2'b00};

  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [1:0]  CFG_RESET     = 2'h0;
  localparam int          PRE_MSB       = 7;
  localparam int          PRE_LSB       = 4;
  localparam int          MOD_MSB       = 3;
  localparam int          MOD_LSB       = 0;
  localparam int          CFG_FULL_BIT  = 0;
  localparam int          CFG_INT_BIT   = 1;

  localparam logic [3:0]  MOD_PASS      = 4'hf;
  localparam logic [4:0]  MOD_LAST_OFS  = 5'h0f;
  localparam logic [3:0]  PRE_CODE_SLOW = 4'h0;
  localparam logic [3:0]  PRE_CODE_MIN  = 4'h5;
  localparam logic [3:0]  PRE_CODE_MAX  = 4'he;
  localparam logic [3:0]  PRE_CODE_OFS  = 4'h4;
  localparam logic [3:0]  PRE_N_SLOW    = 4'hb;
  localparam int          PRE_W         = 10;

  typedef struct packed {
    logic [7:0]        ctrl;
    logic              osc_full;
    logic              int_src;
    logic [1:0]        ext_sync;
    logic              ext_prev;
    logic              half_ph;
    logic [PRE_W-1:0]  pre_cnt;
    logic [4:0]        div_cnt;
    logic              baud_clk;
    logic              baud_tick;
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } state_type;

endpackage

// File: tb/baud_gen_props.sv
// Port checker for the baud rate generator
module baud_gen_props
  import baud_gen_pkg::*;
(
  input wire logic              clock_i,
  input wire logic              rst_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic [DATA_W-1:0] prdata_o,
  input wire logic              baud_clk_o,
  input wire logic              baud_tick_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire acc = psel_i && penable_i && !pready_o;
  wire map = paddr_i == CTRL_ADDR || paddr_i == CFG_ADDR
          || paddr_i == STAT_ADDR;
  a_ready_wait: assert property (acc |=> pready_o)
    else $error("no ready after access cycle");
  a_ready_idle: assert property (!(psel_i && penable_i) |=> !pready_o)
    else $error("ready without access");
  a_ready_once: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_tick_toggle: assert property (baud_tick_o == $changed(baud_clk_o))
    else $error("tick and toggle disagree");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_data_hold: assert property (!pready_o |-> $stable(prdata_o))
    else $error("read data moved");
  a_unmapped_err: assert property (acc && !pwrite_i && !map
    |=> pslverr_o && prdata_o == '0) else $error("unmapped read accepted");
  a_mapped_ok: assert property (acc && !pwrite_i && map |=> !pslverr_o)
    else $error("mapped read refused");
  a_upper_zero: assert property (pready_o && paddr_i == CTRL_ADDR
    |-> prdata_o[31:8] == '0) else $error("upper control bits set");
endmodule // baud_gen_props

bind uart_baud_rate_generator baud_gen_props chk_i (.clock_i(clock_i),
  .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .prdata_o(prdata_o), .baud_clk_o(baud_clk_o),
  .baud_tick_o(baud_tick_o));

// File: tb/testbench.sv
// Self-checking bench of the baud rate generator
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import baud_gen_pkg::*;
  logic              clock_i = 0, rst_i = 1, psel_i = 0, penable_i = 0;
  logic              pwrite_i = 0, rerr, pready_o, pslverr_o;
  logic              baud_clk_o, baud_tick_o;
  logic [ADDR_W-1:0] paddr_i = '0;
  logic [DATA_W-1:0] pwdata_i = '0, rdat, prdata_o, seed = 32'h0000_44b9;
  logic [2:0]        pin_cnt = 3'h0;
  int                error_cnt = 0, comparisons = 0, g;
  uart_baud_rate_generator dut (.clock_i(clock_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hf),
    .external_baud_clock_pin_i(pin_cnt[2]), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .prdata_o(prdata_o), .baud_clk_o(baud_clk_o),
    .baud_tick_o(baud_tick_o));
  always #10 clock_i = ~clock_i;
  // Pin runs free at eight clocks a period, four high and four low
  always @(posedge clock_i) pin_cnt <= pin_cnt + 3'h1;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int exp_gap(input int p, input int k, input bit f);
    return (k == 15 ? 1 : k + 16) * (1 << ((p == 0 ? 11 : p - 4) - 1))
      * (f ? 1 : 2);
  endfunction
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d);
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    // Ready is looked at only as it stands at a rising edge
    do
    begin
      @(posedge clock_i);
    end
    while (pready_o !== 1'b1);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  // Counts clocks up to the next tick, giving up at the limit
  task automatic tick_wait(output int c, input int lim);
    c = 0;
    do
    begin
      @(negedge clock_i);
      c++;
    end
    while (baud_tick_o !== 1'b1 && c < lim);
  endtask
  // First tick after a control write is skipped: counters restart there
  task automatic gap(input logic [7:0] ctrl, output int c);
    apb(1'b1, CTRL_ADDR, {24'h00_0000, ctrl});
    tick_wait(c, 40000);
    tick_wait(c, 40000);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #1_900_000;
    error_cnt++;
    end_of_test;
  end
  initial
  begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    apb(1'b0, CTRL_ADDR, '0);
    chk("ctrl reset", {24'h00_0000, CTRL_RESET}, rdat);
    apb(1'b0, 20'h0_0010, '0);
    chk("unmapped error", 32'h0000_0001, {31'h0, rerr});
    repeat (8)
    begin
      seed = lfsr(seed);
      apb(1'b1, CTRL_ADDR, seed);
      apb(1'b0, CTRL_ADDR, '0);
      chk("ctrl", {24'h00_0000, seed[7:0]}, rdat);
    end
    $display("test registers done");
    apb(1'b1, CFG_ADDR, 32'h0000_0003);
    for (int k = 0; k < 16; k++)
    begin
      gap(8'h50 | 8'(k), g);
      chk("modulus gap", exp_gap(5, k, 1), g);
    end
    $display("test modulus done");
    for (int p = 4; p < 15; p++)
    begin
      gap({4'(p == 4 ? 0 : p), 4'h0}, g);
      chk("prescale gap", exp_gap(p == 4 ? 0 : p, 0, 1), g);
    end
    $display("test prescale done");
    apb(1'b1, CFG_ADDR, 32'h0000_0002);
    gap(8'h53, g);
    chk("halved gap", exp_gap(5, 3, 0), g);
    apb(1'b1, CTRL_ADDR, 32'h0000_0010);
    tick_wait(g, 300);
    chk("stopped", 300, g);
    $display("test halved and stopped done");
    apb(1'b1, CFG_ADDR, 32'h0000_0000);
    gap(8'h12, g);
    chk("pin gap", (2 + 16) * 8, g);
    $display("test external done");
    end_of_test;
  end
endmodule // testbench
